// ---- core/dmo_core.sv ----
// Purpose: graphics memory organisation: aperture, buffer offsets, lock, addressing
// Assumes: register port and requesters are on clk; installed_ram_units is from clk logic
// Notes: register read data return one cycle after the strobe
//
// Notes on behaviour
// [RL1] graphics memory at most 4 MB, above RAM
// [RL2] aperture placed at top of installed RAM
// [RL3] aperture start and size in 512 KB units
// [RL4] accesses use dword offset bits 21:2, byte enables
// [RL5] pixel offset concatenates line and pixel address
// [RL6] four resolutions at 8 and 16 bpp
// [RL7] 8 bpp lines 1024 bytes apart, 2048 at 1280 wide
// [RL8] 16 bpp lines 2048 bytes apart
// [RL9] 1280x1024x16 lines 4096 bytes apart
// [RL10] compressed data fills gap after line
// [RL11] 1024 wide modes: linear compressed buffer
// [RL12] leftmost pixel in lowest byte of word
// [RL13] vga data in 256 KB buffer
// [RL14] refresh directly from vga buffer
// [RL15] refresh directly from frame buffer otherwise
// [RL16] software renders text modes into 8 bpp
// [RL17] 100h window at 8300h, aliased registers
// [RL18] lock register resets zero, reads always allowed
// [RL19] programmable frame, compressed and pointer offsets
// [RL20] line start is base plus scaled line
// [RL21] protected writes dropped unless key present
`timescale 1ns/10ps
module dmo_core #(
    parameter logic [31:0] UNLOCK_KEY = 32'h0000_5a5a,
    parameter logic [21:0] VGA_START = 22'h30_0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire logic [7:0] installed_ram_units,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be_in,
    output logic mem_hit,
    output logic mem_miss,
    output logic [19:0] mem_dw_off,
    output logic [3:0] mem_be,
    input wire logic pix_req,
    input wire logic [10:0] pix_x,
    input wire logic [10:0] pix_y,
    output logic pix_valid,
    output logic [19:0] pix_dw_off,
    output logic [3:0] pix_be,
    output logic [21:0] line_start,
    output logic [21:0] cb_off,
    output logic [19:0] pointer_off,
    output logic refresh_from_vga
);
    import dmo_pkg::*;

    // vga buffer has to fit in the aperture
    if (32'(VGA_START) + VGA_BUF_BYTES > AP_MAX_BYTES) begin : g_bad_vga // RL13
        $error("vga buffer does not fit in the aperture");
    end
    if (VGA_START[1:0] != 2'h0) begin : g_bad_align
        $error("vga buffer must be dword aligned");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] lock_ff;
    logic [31:0] gen_ff;
    logic [23:0] tim_ff;
    logic [23:0] out_ff;
    logic [19:0] fb_ff;
    logic [19:0] cb_ff;
    logic [19:0] cur_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic in_win;
    logic [2:0] idx;
    logic do_wr;
    logic unlocked;
    logic wr_ok;
    logic [31:0] bmask;
    logic [31:0] nxt_lock;
    logic [31:0] nxt_gen;
    logic [23:0] nxt_tim;
    logic [23:0] nxt_out;
    logic [19:0] nxt_fb;
    logic [19:0] nxt_cb;
    logic [19:0] nxt_cur;
    logic [31:0] nxt_rdata;
    logic [7:0] status;

    assign in_win = reg_addr[15:8] == WIN_PAGE; // RL17
    // only bits 4:2 decode, so the 32-byte block repeats across the window
    assign idx = reg_addr[4:2]; // RL17
    assign do_wr = reg_sel && reg_wr && in_win;
    assign unlocked = lock_ff == UNLOCK_KEY; // RL21
    assign wr_ok = do_wr && unlocked; // RL18 RL21
    assign bmask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    assign nxt_lock = (lock_ff & ~bmask) | (reg_wdata & bmask);
    assign nxt_gen = (gen_ff & ~bmask) | (reg_wdata & bmask);
    assign nxt_tim = (tim_ff & ~bmask[23:0]) | (reg_wdata[23:0] & bmask[23:0]);
    assign nxt_out = (out_ff & ~bmask[23:0]) | (reg_wdata[23:0] & bmask[23:0]);
    assign nxt_fb = (fb_ff & ~bmask[21:2]) | (reg_wdata[21:2] & bmask[21:2]); // RL19
    assign nxt_cb = (cb_ff & ~bmask[21:2]) | (reg_wdata[21:2] & bmask[21:2]); // RL19
    assign nxt_cur = (cur_ff & ~bmask[21:2]) | (reg_wdata[21:2] & bmask[21:2]); // RL19

    // the lock register itself is never protected, otherwise no key could get in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_ff <= RST_LOCK; // RL18
        end else if (do_wr && idx == OFS_LOCK[4:2]) begin
            lock_ff <= nxt_lock;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_ff <= RST_GEN;
            tim_ff <= RST_CTL;
            out_ff <= RST_CTL;
        end else if (wr_ok) begin
            if (idx == OFS_GEN[4:2]) gen_ff <= nxt_gen; // RL21
            if (idx == OFS_TIM[4:2]) tim_ff <= nxt_tim; // RL21
            if (idx == OFS_OUT[4:2]) out_ff <= nxt_out; // RL21
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_ff <= RST_OFS;
            cb_ff <= RST_OFS;
            cur_ff <= RST_OFS;
        end else if (wr_ok) begin
            if (idx == OFS_FB[4:2]) fb_ff <= nxt_fb; // RL19
            if (idx == OFS_CB[4:2]) cb_ff <= nxt_cb; // RL19
            if (idx == OFS_CUR[4:2]) cur_ff <= nxt_cur; // RL19
        end
    end

    // ------------------------------------------------------------
    // mode fields
    // ------------------------------------------------------------
    dmo_res_t res;
    logic bpp16;
    logic [2:0] ap_size_f;
    logic [7:0] ap_start_f;
    logic [7:0] ap_base_u;
    logic [3:0] ap_units;
    logic [3:0] cur_shift;

    assign res = dmo_res_t'(gen_ff[GC_RES_LSB +: 2]); // RL6
    assign bpp16 = gen_ff[GC_BPP16]; // RL6
    assign ap_size_f = gen_ff[GC_APSZ_LSB +: 3];
    assign ap_start_f = gen_ff[GC_APST_LSB +: 8];
    // a zero start field places the aperture right at the top of installed ram
    assign ap_base_u = (ap_start_f == 8'h00) ? installed_ram_units : ap_start_f; // RL2
    assign ap_units = {1'b0, ap_size_f} + 4'h1; // RL1 RL3
    assign cur_shift = delta_shift(res, bpp16);
    assign refresh_from_vga = gen_ff[GC_VGA]; // RL14 RL15
    assign pointer_off = cur_ff; // RL19

    // status: line delta shift, lock state, aperture above ram, vga source
    assign status = {cur_shift, unlocked, ap_base_u >= installed_ram_units,
        refresh_from_vga, 1'b0};

    assign nxt_rdata = !in_win ? 32'h0000_0000
        : (idx == OFS_LOCK[4:2]) ? lock_ff // RL18
        : (idx == OFS_GEN[4:2]) ? gen_ff
        : (idx == OFS_TIM[4:2]) ? {status, tim_ff}
        : (idx == OFS_OUT[4:2]) ? {8'h00, out_ff}
        : (idx == OFS_FB[4:2]) ? {10'h000, fb_ff, 2'h0}
        : (idx == OFS_CB[4:2]) ? {10'h000, cb_ff, 2'h0}
        : (idx == OFS_CUR[4:2]) ? {10'h000, cur_ff, 2'h0}
        : RSVD_VAL;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= reg_sel;
            if (reg_sel && !reg_wr) rdata_ff <= nxt_rdata; // RL18
        end
    end
    assign reg_rdata = rdata_ff;
    assign reg_ack = ack_ff;

    // ------------------------------------------------------------
    // aperture decode
    // ------------------------------------------------------------
    logic [12:0] addr_u;
    logic [12:0] rel_u;
    logic ap_in;
    logic hit_ff;
    logic miss_ff;
    logic [19:0] dw_ff;
    logic [3:0] mbe_ff;

    assign addr_u = mem_addr[31:AP_UNIT_LSB];
    assign rel_u = addr_u - {5'h00, ap_base_u};
    assign ap_in = (addr_u >= {5'h00, ap_base_u}) && (rel_u < {9'h000, ap_units}); // RL1 RL3

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_ff <= 1'b0;
            miss_ff <= 1'b0;
            dw_ff <= 20'h0_0000;
            mbe_ff <= 4'h0;
        end else begin
            hit_ff <= mem_req && ap_in;
            miss_ff <= mem_req && !ap_in;
            if (mem_req && ap_in) begin
                dw_ff <= {rel_u[2:0], mem_addr[18:2]}; // RL4
                mbe_ff <= mem_be_in; // RL4
            end
        end
    end
    assign mem_hit = hit_ff;
    assign mem_miss = miss_ff;
    assign mem_dw_off = dw_ff;
    assign mem_be = mbe_ff;

    // ------------------------------------------------------------
    // display address generation
    // ------------------------------------------------------------
    dmo_cfg_if cfg ();
    assign cfg.res = res;
    assign cfg.bpp16 = bpp16;
    assign cfg.vga_src = refresh_from_vga;
    assign cfg.fb_start = fb_ff;
    assign cfg.cb_start = cb_ff;
    assign cfg.cb_line_dw = gen_ff[GC_CBSZ_LSB +: 8];

    dmo_addr_gen #(
        .VGA_START(VGA_START)
    ) u_gen (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg),
        .req(pix_req),
        .pix_x(pix_x),
        .pix_y(pix_y),
        .valid_ff(pix_valid),
        .line_start_ff(line_start),
        .pix_off_ff(pix_dw_off),
        .cb_off_ff(cb_off)
    );

    dmo_pix_pack u_pack (
        .clk(clk),
        .rst_n(rst_n),
        .req(pix_req),
        .bpp16(bpp16),
        .x_lo(pix_x[1:0]),
        .be_ff(pix_be)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb_clk @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [21:0] chk_base;
    assign chk_base = refresh_from_vga ? VGA_START : {fb_ff, 2'h0};

    lock_guard_a: assert property ( // RL21
        do_wr && !unlocked && idx == OFS_FB[4:2] |=> $stable(fb_ff))
        else $error("locked write changed frame buffer start");
    read_ok_a: assert property ( // RL18
        reg_sel && !reg_wr && in_win && idx == OFS_FB[4:2] && !unlocked
        |=> reg_ack && reg_rdata[21:2] == fb_ff)
        else $error("read of protected register not answered");
    win_alias_a: assert property ( // RL17
        reg_sel && !reg_wr && in_win && idx == OFS_GEN[4:2] |=> reg_rdata == $past(gen_ff))
        else $error("aliased read does not return the register");
    ap_limit_a: assert property ( // RL1
        mem_req && (addr_u - {5'h00, ap_base_u}) >= 13'h0008 |=> !mem_hit && mem_miss)
        else $error("hit beyond the aperture limit");
    ap_top_a: assert property ( // RL2
        mem_req && ap_start_f == 8'h00 && addr_u == {5'h00, installed_ram_units}
        |=> mem_hit && mem_dw_off[19:17] == 3'h0)
        else $error("aperture not at top of ram");
    dw_offset_a: assert property ( // RL4
        mem_hit |-> mem_dw_off[16:0] == $past(mem_addr[18:2]) && mem_be == $past(mem_be_in))
        else $error("dword offset or byte enables wrong");
    delta8_a: assert property ( // RL7
        pix_req && !bpp16 && res != RES_1280 ##1 $stable(chk_base)
        |-> line_start == chk_base + {1'b0, $past(pix_y), 10'h000})
        else $error("8 bpp line delta wrong");
    delta16_a: assert property ( // RL8
        pix_req && bpp16 && res != RES_1280 ##1 $stable(chk_base)
        |-> line_start == 22'(chk_base + {$past(pix_y), 11'h000}))
        else $error("16 bpp line delta wrong");
    delta1280_a: assert property ( // RL9
        pix_req && bpp16 && res == RES_1280 && pix_y < 11'h400 ##1 $stable(chk_base)
        |-> line_start == 22'(chk_base + {$past(pix_y[9:0]), 12'h000}))
        else $error("1280 line delta wrong");
    cb_gap_a: assert property ( // RL10
        pix_req && res == RES_640 && !bpp16 |=> cb_off == line_start + 22'h280)
        else $error("compressed data not after the line");
    cb_linear_a: assert property ( // RL11
        pix_req && res == RES_1024 ##1 $stable(cb_ff) && $stable(gen_ff)
        |-> cb_off == 22'({cb_ff, 2'h0} + $past(pix_y) * {gen_ff[GC_CBSZ_LSB +: 8], 2'h0}))
        else $error("linear compressed buffer address wrong");
    pack_a: assert property ( // RL12
        pix_req && !bpp16 |=> pix_be == 4'(4'h1 << $past(pix_x[1:0])))
        else $error("8 bpp byte lane wrong");
    vga_src_a: assert property ( // RL14
        pix_req && refresh_from_vga && pix_y == 11'h000 && pix_x == 11'h000
        |=> pix_dw_off == VGA_START[21:2])
        else $error("vga refresh not from vga buffer");

    unlock_c: cover property (do_wr && idx == OFS_LOCK[4:2] ##1 unlocked ##[1:4] wr_ok);
    hit_c: cover property (mem_req && ap_in ##1 mem_hit);
    gap_c: cover property (pix_req && res == RES_800 && bpp16 ##1 pix_valid);
    vga_c: cover property (pix_req && refresh_from_vga ##1 pix_valid);
endmodule : dmo_core

// ---- core/dmo_pkg.sv ----
// Purpose: shared constants and helpers of the display memory organisation block
// Assumes: registers are reached at their control-space offsets, 32-bit words
// Notes: offsets are byte offsets from control_space_base
package dmo_pkg;
    // ------------------------------------------------------------
    // register window
    // ------------------------------------------------------------
    localparam logic [7:0] WIN_PAGE = 8'h83;
    localparam logic [15:0] OFS_LOCK = 16'h8300;
    localparam logic [15:0] OFS_GEN = 16'h8304;
    localparam logic [15:0] OFS_TIM = 16'h8308;
    localparam logic [15:0] OFS_OUT = 16'h830c;
    localparam logic [15:0] OFS_FB = 16'h8310;
    localparam logic [15:0] OFS_CB = 16'h8314;
    localparam logic [15:0] OFS_CUR = 16'h8318;
    localparam logic [15:0] OFS_RSVD = 16'h831c;
    localparam logic [31:0] RST_LOCK = 32'h0000_0000;
    localparam logic [31:0] RST_GEN = 32'h0000_0000;
    localparam logic [23:0] RST_CTL = 24'h00_0000;
    localparam logic [19:0] RST_OFS = 20'h0_0000;
    localparam logic [31:0] RSVD_VAL = 32'h0000_0000;
    // ------------------------------------------------------------
    // general_control fields
    // ------------------------------------------------------------
    localparam int GC_RES_LSB = 0;
    localparam int GC_BPP16 = 2;
    localparam int GC_VGA = 3;
    localparam int GC_APSZ_LSB = 4;
    localparam int GC_APST_LSB = 8;
    localparam int GC_CBSZ_LSB = 16;
    localparam int ST_LSB = 24;
    // ------------------------------------------------------------
    // aperture and buffers
    // ------------------------------------------------------------
    localparam int AP_UNIT_LSB = 19;
    localparam logic [3:0] AP_MAX_UNITS = 4'h8;
    localparam int unsigned VGA_BUF_BYTES = 262144;
    localparam int unsigned AP_MAX_BYTES = 4194304;
    localparam logic [3:0] LSH_8 = 4'ha;
    localparam logic [3:0] LSH_16 = 4'hb;
    localparam logic [3:0] LSH_1280_16 = 4'hc;
    localparam logic [3:0] LSH_1280_8 = 4'hb;

    typedef enum logic [1:0] {
        RES_640 = 2'h0,
        RES_800 = 2'h1,
        RES_1024 = 2'h2,
        RES_1280 = 2'h3
    } dmo_res_t;

    function automatic logic [3:0] delta_shift(input dmo_res_t res, input logic bpp16);
        if (res == RES_1280) begin
            delta_shift = bpp16 ? LSH_1280_16 : LSH_1280_8;
        end else begin
            delta_shift = bpp16 ? LSH_16 : LSH_8;
        end
    endfunction : delta_shift

    function automatic logic [21:0] line_bytes(input dmo_res_t res, input logic bpp16);
        logic [21:0] w;
        w = 22'h0;
        unique case (res)
            RES_640: w = 22'h280;
            RES_800: w = 22'h320;
            RES_1024: w = 22'h400;
            RES_1280: w = 22'h500;
        endcase
        line_bytes = bpp16 ? {w[20:0], 1'b0} : w;
    endfunction : line_bytes
endpackage : dmo_pkg

// ---- core/dmo_cfg_if.sv ----
// Purpose: carries the memory organisation settings to the address generator
// Assumes: one clock domain
// Notes: offsets are dword offsets within the aperture
`timescale 1ns/10ps
interface dmo_cfg_if;
    import dmo_pkg::*;
    dmo_res_t res;
    logic bpp16;
    logic vga_src;
    logic [19:0] fb_start;
    logic [19:0] cb_start;
    logic [7:0] cb_line_dw;
    modport src (output res, output bpp16, output vga_src, output fb_start, output cb_start,
        output cb_line_dw);
    modport gen (input res, input bpp16, input vga_src, input fb_start, input cb_start,
        input cb_line_dw);
endinterface : dmo_cfg_if

// ---- core/dmo_pix_pack.sv ----
// Purpose: byte enables of one pixel inside its 32-bit word
// Assumes: leftmost pixel sits in the lowest byte
// Notes: one cycle of latency, matching the address generator
`timescale 1ns/10ps
module dmo_pix_pack (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic bpp16,
    input wire logic [1:0] x_lo,
    output logic [3:0] be_ff
);
    import dmo_pkg::*;
    logic [3:0] nxt_be;
    // ------------------------------------------------------------
    // one lane per byte
    // ------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_lane
        localparam logic [1:0] LANE = 2'(i);
        assign nxt_be[i] = bpp16 ? (LANE[1] == x_lo[0]) : (LANE == x_lo); // RL12
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            be_ff <= 4'h0;
        end else if (req) begin
            be_ff <= nxt_be;
        end
    end
endmodule : dmo_pix_pack

// ---- core/dmo_addr_gen.sv ----
// Purpose: line start, pixel and compressed-line offsets for the display
// Assumes: the mode and offsets are steady while a frame is fetched
// Notes: results appear one cycle after the request
`timescale 1ns/10ps
module dmo_addr_gen #(
    parameter logic [21:0] VGA_START = 22'h00_0000
) (
    input wire logic clk,
    input wire logic rst_n,
    dmo_cfg_if.gen cfg,
    input wire logic req,
    input wire logic [10:0] pix_x,
    input wire logic [10:0] pix_y,
    output logic valid_ff,
    output logic [21:0] line_start_ff,
    output logic [19:0] pix_off_ff,
    output logic [21:0] cb_off_ff
);
    import dmo_pkg::*;
    logic [3:0] shift;
    logic [21:0] x_bytes;
    logic [21:0] y_rel;
    logic [21:0] xy;
    logic [21:0] base;
    logic [21:0] lbytes;
    logic [21:0] nxt_line;
    logic [21:0] nxt_pix;
    logic [21:0] nxt_cb;
    logic gap;
    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------
    assign shift = delta_shift(cfg.res, cfg.bpp16); // RL7 RL8 RL9
    assign x_bytes = cfg.bpp16 ? {10'h0, pix_x, 1'b0} : {11'h000, pix_x};
    assign y_rel = 22'({11'h000, pix_y} << shift);
    // x never reaches the delta, so or-ing is a plain concatenation, no multiplier
    assign xy = y_rel | x_bytes; // RL5
    assign base = cfg.vga_src ? VGA_START : {cfg.fb_start, 2'h0}; // RL14 RL15
    assign nxt_line = base + y_rel; // RL20
    assign nxt_pix = base + xy;
    assign lbytes = line_bytes(cfg.res, cfg.bpp16);
    assign gap = lbytes < (22'h1 << shift);
    assign nxt_cb = gap ? nxt_line + lbytes // RL10
        : {cfg.cb_start, 2'h0} + 22'(pix_y * {cfg.cb_line_dw, 2'h0}); // RL11
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            line_start_ff <= 22'h0;
            pix_off_ff <= 20'h0;
            cb_off_ff <= 22'h0;
        end else begin
            valid_ff <= req;
            if (req) begin
                line_start_ff <= nxt_line;
                pix_off_ff <= nxt_pix[21:2];
                cb_off_ff <= nxt_cb;
            end
        end
    end
endmodule : dmo_addr_gen

// ---- bench/dmo_req_model.sv ----
// Purpose: requester model for the aperture and display address ports
// Assumes: requests start at the falling edge and are taken at the next rising edge
// Notes: released lines show inverted values so that a stale value is never read as valid
`timescale 1ns/10ps
module dmo_req_model (
    input wire logic clk,
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be_in,
    output logic pix_req,
    output logic [10:0] pix_x,
    output logic [10:0] pix_y
);
    // ------------------------------------------------------------
    // one-cycle requests
    // ------------------------------------------------------------
    initial begin
        mem_req = 1'b0;
        mem_addr = 32'h0;
        mem_be_in = 4'h0;
        pix_req = 1'b0;
        pix_x = 11'h0;
        pix_y = 11'h0;
    end

    task automatic mem(input logic [31:0] a, input logic [3:0] be);
        @(negedge clk);
        mem_req = 1'b1;
        mem_addr = a;
        mem_be_in = be;
        @(negedge clk);
        mem_req = 1'b0;
        mem_addr = ~a;
        mem_be_in = ~be;
    endtask : mem

    task automatic pix(input logic [10:0] x, input logic [10:0] y);
        @(negedge clk);
        pix_req = 1'b1;
        pix_x = x;
        pix_y = y;
        @(negedge clk);
        pix_req = 1'b0;
        pix_x = ~x;
        pix_y = ~y;
    endtask : pix
endmodule : dmo_req_model

// ---- bench/dmo_core_tb_top.sv ----
// Purpose: self-checking bench of the display memory organisation block
// Assumes: 200 MHz clock, inputs change at the falling edge
// Notes: register rows first, then reset, lock, modes and aperture by hand
`timescale 1ns/10ps
module dmo_core_tb_top;
    import dmo_pkg::*;
    localparam logic [31:0] KEY = 32'h0000_5a5a;
    localparam logic [21:0] VGA = 22'h30_0000;
    typedef struct {logic wr; logic [15:0] a; logic [31:0] d; logic [31:0] e;} dmo_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_sel = 1'b0;
    logic reg_wr = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [3:0] reg_be = 4'hf;
    logic [31:0] reg_wdata = 32'h0;
    logic [7:0] ram_u = 8'h10;
    logic [31:0] reg_rdata, mem_addr;
    logic reg_ack, mem_req, mem_hit, mem_miss, pix_req, pix_valid, refresh_from_vga;
    logic [3:0] mem_be_in, mem_be, pix_be;
    logic [19:0] mem_dw_off, pix_dw_off, pointer_off;
    logic [10:0] pix_x, pix_y;
    logic [21:0] line_start, cb_off;
    int error_cnt = 0;
    int n_checks = 0;
    dmo_row_t rows [11] = '{'{1'b1, 16'h8300, KEY, 32'h0}, '{1'b1, 16'h8310, 32'hffff_ffff, 32'h0},
        '{1'b0, 16'h8310, 32'h0, 32'h003f_fffc}, '{1'b1, 16'h8314, 32'h0001_2344, 32'h0},
        '{1'b0, 16'h8314, 32'h0, 32'h0001_2344}, '{1'b1, 16'h8318, 32'h0000_0100, 32'h0},
        '{1'b0, 16'h8318, 32'h0, 32'h0000_0100}, '{1'b0, 16'h831c, 32'h0, 32'h0},
        '{1'b0, 16'h8320, 32'h0, KEY}, '{1'b1, 16'h8410, 32'hffff_ffff, 32'h0},
        '{1'b0, 16'h8330, 32'h0, 32'h003f_fffc}};

    always #2.5 clk = ~clk;

    dmo_core #(.UNLOCK_KEY(KEY), .VGA_START(VGA)) i_dmo_core (.clk(clk), .rst_n(rst_n),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .installed_ram_units(ram_u), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_be_in(mem_be_in), .mem_hit(mem_hit), .mem_miss(mem_miss), .mem_dw_off(mem_dw_off),
        .mem_be(mem_be), .pix_req(pix_req), .pix_x(pix_x), .pix_y(pix_y), .pix_valid(pix_valid),
        .pix_dw_off(pix_dw_off), .pix_be(pix_be), .line_start(line_start), .cb_off(cb_off),
        .pointer_off(pointer_off), .refresh_from_vga(refresh_from_vga));
    dmo_req_model i_dmo_req_model (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_be_in(mem_be_in), .pix_req(pix_req), .pix_x(pix_x), .pix_y(pix_y));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rg(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_sel = 1'b1;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        chk({31'h0, reg_ack}, 32'h1);
        reg_sel = 1'b0;
        reg_wdata = ~d;
        @(negedge clk);
        chk({31'h0, reg_ack}, 32'h0);
    endtask : rg

    task automatic pix_mode(input logic [1:0] r, input logic b, input logic v);
        logic [3:0] sh;
        logic [21:0] lb, ls, cb;
        sh = 4'ha + {3'h0, b} + ((r == 2'h3) ? 4'h1 : 4'h0);
        lb = (r == 2'h0) ? 22'h280 : (r == 2'h1) ? 22'h320 : (r == 2'h2) ? 22'h400 : 22'h500;
        lb = lb << b;
        ls = (v ? VGA : 22'h1000) + (22'h3 << sh);
        cb = (lb < (22'h1 << sh)) ? ls + lb : 22'h20_0180;
        rg(1'b1, 16'h8304, {8'h00, 8'h20, 8'h00, 4'h7, v, b, r});
        i_dmo_req_model.pix(11'h5, 11'h3);
        chk({31'h0, pix_valid}, 32'h1);
        chk({10'h0, line_start}, {10'h0, ls});
        chk({12'h0, pix_dw_off}, {12'h0, (ls + (22'h5 << b)) >> 2});
        chk({28'h0, pix_be}, b ? 32'hc : 32'h2);
        chk({31'h0, refresh_from_vga}, {31'h0, v});
        if (!v) begin
            chk({10'h0, cb_off}, {10'h0, cb});
        end
    endtask : pix_mode

    task automatic mm(input logic [31:0] a, input logic h, input logic [19:0] dw);
        i_dmo_req_model.mem(a, 4'h5);
        chk({30'h0, mem_hit, mem_miss}, {30'h0, h, ~h});
        if (h) begin
            chk({8'h0, mem_be, mem_dw_off}, {8'h0, 4'h5, dw});
        end
    endtask : mm

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            rg(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(reg_rdata, rows[i].e);
        end
        chk({12'h0, pointer_off}, 32'h40);
        // second reset in mid-run: lock closes again
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk({12'h0, pointer_off}, 32'h0);
        rg(1'b0, 16'h8300, 32'h0);
        chk(reg_rdata, 32'h0);
        rg(1'b1, 16'h8300, KEY ^ 32'h1);
        rg(1'b1, 16'h8310, 32'h0000_1000);
        rg(1'b0, 16'h8310, 32'h0);
        chk(reg_rdata, 32'h0);
        rg(1'b1, 16'h8300, KEY);
        rg(1'b1, 16'h8310, 32'h0000_1000);
        rg(1'b1, 16'h8314, 32'h0020_0000);
        for (int m = 0; m < 8; m++) begin
            pix_mode(m[2:1], m[0], 1'b0);
        end
        pix_mode(2'h0, 1'b0, 1'b1);
        i_dmo_req_model.pix(11'h0, 11'h0);
        chk({12'h0, pix_dw_off}, {12'h0, VGA[21:2]});
        mm(32'h0080_1234, 1'b1, 20'h0048d);
        mm(32'h00bf_fffc, 1'b1, 20'hfffff);
        mm(32'h007f_fffc, 1'b0, 20'h0);
        mm(32'h00c0_0000, 1'b0, 20'h0);
        rg(1'b1, 16'h8304, 32'h0000_2000);
        mm(32'h0100_0010, 1'b1, 20'h00004);
        mm(32'h0108_0000, 1'b0, 20'h0);
        rg(1'b0, 16'h8324, 32'h0);
        chk(reg_rdata, 32'h0000_2000);
        wrap_up();
    end
endmodule : dmo_core_tb_top
